// File: design/qpv_pkg.sv
package qpv_pkg;
	localparam int unsigned POS_W = 32;
	localparam int unsigned VEL_W = 32;
	localparam int unsigned DIV_W = 3;
	localparam int unsigned EVT_N = 4;
	localparam int unsigned EVT_INDEX = 0;
	localparam int unsigned EVT_TIMER = 1;
	localparam int unsigned EVT_DIR = 2;
	localparam int unsigned EVT_ERROR = 3;
	localparam logic [31:0] POS_RESET = 32'h0000_0000;
	localparam logic [31:0] LIMIT_RESET = 32'hffff_ffff;
	localparam logic [31:0] PERIOD_RESET = 32'h0000_0001;
endpackage : qpv_pkg

// File: design/qpv_sync.sv
`timescale 1ns/10ps
`default_nettype none
module qpv_sync #(
	parameter int unsigned WIDTH = 3
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;
	// Two flops; only the second stage is seen outside
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			stage1 <= '0;
			sync_out <= '0;
		end else begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end
endmodule : qpv_sync
`default_nettype wire

// File: design/qpv_top.sv
`timescale 1ns/10ps
`default_nettype none
module qpv_top #(
	parameter int unsigned POS_W = qpv_pkg::POS_W,
	parameter int unsigned VEL_W = qpv_pkg::VEL_W
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic phase_a_input,
	input wire logic phase_b_input,
	input wire logic index_input,
	input wire logic module_enable,
	input wire logic step_dir_mode,
	input wire logic count_both_edges,
	input wire logic swap_inputs,
	input wire logic index_reset_mode,
	input wire logic [POS_W-1:0] position_limit,
	input wire logic position_write,
	input wire logic [POS_W-1:0] position_write_value,
	input wire logic velocity_enable,
	input wire logic [qpv_pkg::DIV_W-1:0] velocity_prediv,
	input wire logic [VEL_W-1:0] velocity_period,
	input wire logic [qpv_pkg::EVT_N-1:0] irq_mask,
	input wire logic irq_clear_write,
	input wire logic [qpv_pkg::EVT_N-1:0] irq_clear_bits,
	output logic [POS_W-1:0] position,
	output logic direction_reverse,
	output logic phase_error,
	output logic [VEL_W-1:0] velocity_running,
	output logic [VEL_W-1:0] velocity_count,
	output logic [qpv_pkg::EVT_N-1:0] irq_raw,
	output logic [qpv_pkg::EVT_N-1:0] irq_masked,
	output logic irq
);
	logic [2:0] sync_in;
	logic a_q, b_q, idx_q;
	logic [VEL_W-1:0] timer;
	logic [7:0] div_cnt;

	qpv_sync #(.WIDTH(3)) u_sync (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.async_in({index_input, phase_b_input, phase_a_input}),
		.sync_out(sync_in)
	);

	// Channel swap ahead of all decoding
	wire chan_a = swap_inputs ? sync_in[1] : sync_in[0];
	wire chan_b = swap_inputs ? sync_in[0] : sync_in[1];
	wire idx = sync_in[2];
	wire a_edge = chan_a ^ a_q;
	wire b_edge = chan_b ^ b_q;
	wire idx_rise = idx & ~idx_q;
	wire run = module_enable;

	// Quadrature: after an A edge, A != B means A leads (forward)
	wire quad_a_rev = ~(chan_a ^ chan_b);
	wire quad_b_rev = chan_a ^ chan_b;
	wire both_edge = a_edge & b_edge;
	// In quadrature mode a double edge is an error in either counting setting and never a count
	wire quad_step = (count_both_edges ? (a_edge | b_edge) : a_edge) & ~both_edge;
	wire quad_rev = a_edge ? quad_a_rev : quad_b_rev;
	wire sd_step = a_edge;
	wire sd_rev = chan_b;
	wire step = run & (step_dir_mode ? sd_step : quad_step);
	wire step_rev = step_dir_mode ? sd_rev : quad_rev;
	wire err_evt = run & ~step_dir_mode & both_edge;
	wire dir_evt = step & (step_rev != direction_reverse);
	wire idx_evt = run & idx_rise;

	// Position with wrap at limit
	wire at_top = (position >= position_limit);
	wire at_zero = (position == '0);
	wire [POS_W-1:0] pos_inc = at_top ? '0 : POS_W'(position + 1'b1);
	wire [POS_W-1:0] pos_dec = at_zero ? position_limit : POS_W'(position - 1'b1);
	wire [POS_W-1:0] idx_load = direction_reverse ? position_limit :
		qpv_pkg::POS_RESET[POS_W-1:0];
	wire [POS_W-1:0] next_position =
		position_write ? position_write_value :
		(idx_evt && index_reset_mode) ? idx_load :
		step ? (step_rev ? pos_dec : pos_inc) : position;

	// Velocity predivider and period timer
	wire [7:0] div_mask = 8'((9'h001 << velocity_prediv) - 9'h001);
	wire vel_run = run & velocity_enable;
	wire div_hit = ((div_cnt & div_mask) == div_mask);
	wire vel_pulse = vel_run & step & div_hit;
	wire period_end = vel_run & (timer >= VEL_W'(velocity_period - 1'b1));
	wire [VEL_W-1:0] next_running = period_end ? '0 :
		VEL_W'(velocity_running + {{(VEL_W-1){1'b0}}, vel_pulse});
	wire [qpv_pkg::EVT_N-1:0] evt;
	assign evt[qpv_pkg::EVT_INDEX] = idx_evt;
	assign evt[qpv_pkg::EVT_TIMER] = period_end;
	assign evt[qpv_pkg::EVT_DIR] = dir_evt;
	assign evt[qpv_pkg::EVT_ERROR] = err_evt;
	wire [qpv_pkg::EVT_N-1:0] clr = irq_clear_write ? irq_clear_bits : '0;
	wire [qpv_pkg::EVT_N-1:0] next_raw = evt | (irq_raw & ~clr);
	wire [qpv_pkg::EVT_N-1:0] next_masked = next_raw & irq_mask;

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			a_q <= 1'b0;
			b_q <= 1'b0;
			idx_q <= 1'b0;
		end else begin
			a_q <= chan_a;
			b_q <= chan_b;
			idx_q <= idx;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			position <= qpv_pkg::POS_RESET[POS_W-1:0];
			direction_reverse <= 1'b0;
			phase_error <= 1'b0;
		end else begin
			position <= next_position;
			if (step)
				direction_reverse <= step_rev;
			if (err_evt)
				phase_error <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			timer <= '0;
			div_cnt <= 8'h00;
			velocity_running <= '0;
			velocity_count <= '0;
		end else begin
			if (!vel_run) begin
				timer <= '0;
				div_cnt <= 8'h00;
			end else begin
				timer <= period_end ? '0 : VEL_W'(timer + 1'b1);
				if (step)
					div_cnt <= 8'(div_cnt + 8'h01);
			end
			velocity_running <= vel_run ? next_running : velocity_running;
			if (period_end)
				velocity_count <= VEL_W'(velocity_running + {{(VEL_W-1){1'b0}}, vel_pulse});
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			irq_raw <= '0;
			irq_masked <= '0;
			irq <= 1'b0;
		end else begin
			irq_raw <= next_raw;
			irq_masked <= next_masked;
			irq <= |next_masked;
		end
	end

	// Position guards
	a_pos_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
		!module_enable && !position_write |=> $stable(position))
		else $error("position moved while disabled");
	a_pos_load: assert property (@(posedge sys_clk) disable iff (!rstn)
		position_write |=> position == $past(position_write_value))
		else $error("position write lost");
	a_wrap_fwd: assert property (@(posedge sys_clk) disable iff (!rstn)
		step && !step_rev && !position_write && !(idx_evt && index_reset_mode)
		&& position == position_limit |=> position == '0)
		else $error("forward wrap wrong");
	a_wrap_rev: assert property (@(posedge sys_clk) disable iff (!rstn)
		step && step_rev && !position_write && !(idx_evt && index_reset_mode)
		&& position == '0 |=> position == $past(position_limit))
		else $error("reverse wrap wrong");
	a_idx_load: assert property (@(posedge sys_clk) disable iff (!rstn)
		idx_evt && index_reset_mode && !position_write
		|=> position == ($past(direction_reverse) ? $past(position_limit) : '0))
		else $error("index reset value wrong");
	a_idx_keep: assert property (@(posedge sys_clk) disable iff (!rstn)
		idx_evt && !index_reset_mode && !position_write && !step |=> $stable(position))
		else $error("index moved relative count");

	// Error guards
	a_err_hold_pos: assert property (@(posedge sys_clk) disable iff (!rstn)
		err_evt && !position_write && !(idx_evt && index_reset_mode) |=> $stable(position))
		else $error("double edge was counted");
	a_err_flag: assert property (@(posedge sys_clk) disable iff (!rstn)
		err_evt |=> phase_error && irq_raw[qpv_pkg::EVT_ERROR])
		else $error("double edge not flagged");
	a_err_sticky: assert property (@(posedge sys_clk) disable iff (!rstn)
		phase_error |=> phase_error)
		else $error("error indicator dropped");

	// Direction guards
	a_dir_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
		!step |=> $stable(direction_reverse))
		else $error("direction changed without step");
	a_dir_follow: assert property (@(posedge sys_clk) disable iff (!rstn)
		step |=> direction_reverse == $past(step_rev))
		else $error("direction not taken from step");
	a_dir_event: assert property (@(posedge sys_clk) disable iff (!rstn)
		dir_evt |=> irq_raw[qpv_pkg::EVT_DIR])
		else $error("direction event lost");

	// Velocity guards
	a_vel_gate: assert property (@(posedge sys_clk) disable iff (!rstn)
		!velocity_enable |=> velocity_running == $past(velocity_running))
		else $error("velocity counted while off");
	a_vel_idle: assert property (@(posedge sys_clk) disable iff (!rstn)
		!(module_enable && velocity_enable) |=> $stable(velocity_running))
		else $error("velocity counted while position off");
	a_period_latch: assert property (@(posedge sys_clk) disable iff (!rstn)
		period_end |=> velocity_running == '0
		&& velocity_count == VEL_W'($past(velocity_running) + $past(vel_pulse)))
		else $error("period total not latched");

	// Interrupt guards
	a_irq_mask: assert property (@(posedge sys_clk) disable iff (!rstn)
		irq == |(irq_raw & $past(irq_mask)))
		else $error("irq not equal to enabled status");
	a_masked_view: assert property (@(posedge sys_clk) disable iff (!rstn)
		irq_masked == (irq_raw & $past(irq_mask)))
		else $error("masked view wrong");
	a_set_wins: assert property (@(posedge sys_clk) disable iff (!rstn)
		evt[qpv_pkg::EVT_TIMER] |=> irq_raw[qpv_pkg::EVT_TIMER])
		else $error("timer event lost");
	a_idx_event: assert property (@(posedge sys_clk) disable iff (!rstn)
		idx_evt |=> irq_raw[qpv_pkg::EVT_INDEX])
		else $error("index event lost");
	a_clear_bit: assert property (@(posedge sys_clk) disable iff (!rstn)
		irq_clear_write && irq_clear_bits[qpv_pkg::EVT_DIR] && !dir_evt
		|=> !irq_raw[qpv_pkg::EVT_DIR])
		else $error("clear ignored");
endmodule : qpv_top
`default_nettype wire

// File: test/qpv_encoder.sv
`timescale 1ns/10ps
`default_nettype none
module qpv_encoder (
	input wire logic sys_clk,
	input wire logic step,
	input wire logic rev,
	input wire logic sd,
	input wire logic glitch,
	input wire logic idx_in,
	output logic a,
	output logic b,
	output logic index
);
	logic [1:0] p = 2'h0;
	// Gray walk: forward lets channel A lead B by a quarter cycle
	always @(posedge sys_clk) begin
		if (glitch) begin
			p <= p + 2'h2;
		end else if (step) begin
			p <= rev ? p - 2'h1 : p + 2'h1;
		end
	end
	assign a = sd ? p[0] : p[0] ^ p[1];
	assign b = sd ? rev : p[1];
	assign index = idx_in;
endmodule : qpv_encoder
`default_nettype wire

// File: test/qpv_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module qpv_top_tb;
	logic sys_clk = 1'b0, rstn = 1'b0, step = 1'b0, rev = 1'b0, sd = 1'b0, gl = 1'b0;
	logic idx = 1'b0, en = 1'b0, both = 1'b1, swp = 1'b0, irm = 1'b0, pw = 1'b0;
	logic ve = 1'b0, cw = 1'b0, a, b, ix;
	logic [31:0] lim = 32'h5, pwv = 32'h0, rnd = 32'h10b7, ep = 32'h0, keep = 32'h0;
	logic [2:0] pd = 3'h0;
	logic [3:0] msk = 4'h0, cb = 4'h0;
	wire [31:0] pos, vr, vc;
	wire [3:0] raw, msd;
	wire dr, pe, irq;
	int num_errors = 0, num_checks = 0, cyc = 0;
	initial forever #20 sys_clk = ~sys_clk;
	qpv_encoder i_qpv_encoder(.sys_clk(sys_clk), .step(step), .rev(rev), .sd(sd), .glitch(gl),
		.idx_in(idx), .a(a), .b(b), .index(ix));
	qpv_top i_qpv_top(.sys_clk(sys_clk), .rstn(rstn), .phase_a_input(a), .phase_b_input(b),
		.index_input(ix), .module_enable(en), .step_dir_mode(sd), .count_both_edges(both),
		.swap_inputs(swp), .index_reset_mode(irm), .position_limit(lim), .position_write(pw),
		.position_write_value(pwv), .velocity_enable(ve), .velocity_prediv(pd),
		.velocity_period(32'h10), .irq_mask(msk), .irq_clear_write(cw), .irq_clear_bits(cb),
		.position(pos), .direction_reverse(dr), .phase_error(pe), .velocity_running(vr),
		.velocity_count(vc), .irq_raw(raw), .irq_masked(msd), .irq(irq));
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction : xs
	function automatic logic [31:0] nxt(input logic [31:0] p, input logic r);
		if (r) return (p == 32'h0) ? lim : p - 32'h1;
		return (p >= lim) ? 32'h0 : p + 32'h1;
	endfunction : nxt
	task automatic chk(input logic [63:0] g, input logic [63:0] e);
		num_checks++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic stop_test();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : stop_test
	task automatic mv(input logic r, input logic g);
		rev <= r;
		step <= ~g;
		gl <= g;
		@(posedge sys_clk);
		step <= 1'b0;
		gl <= 1'b0;
		repeat (6) @(posedge sys_clk);
		if (!g && en) ep = nxt(ep, r ^ swp);
	endtask : mv
	task automatic pulse(input logic kind, input logic [3:0] bits);
		cb <= bits;
		if (kind) idx <= 1'b1;
		else cw <= 1'b1;
		repeat (3) @(posedge sys_clk);
		idx <= 1'b0;
		cw <= 1'b0;
		repeat (6) @(posedge sys_clk);
	endtask : pulse
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors++;
			stop_test();
		end
	end
	initial begin
		repeat (6) @(posedge sys_clk);
		rstn <= 1'b1;
		repeat (4) @(posedge sys_clk);
		chk({pos, raw}, 36'h0);
		en <= 1'b1;
		@(posedge sys_clk);
		for (int i = 0; i < 40; i++) begin
			rnd = xs(rnd);
			mv(rnd[0], 1'b0);
			chk(pos, ep);
			chk(dr, rnd[0]);
		end
		pulse(1'b0, 4'hf);
		chk(raw, 4'h0);
		mv(1'b0, 1'b0);
		mv(1'b1, 1'b0);
		chk(raw, 4'h4);
		msk <= 4'h3;
		repeat (2) @(posedge sys_clk);
		chk({irq, msd}, 5'h0);
		msk <= 4'h4;
		repeat (2) @(posedge sys_clk);
		chk({irq, msd}, 5'h14);
		pulse(1'b0, 4'hb);
		chk(raw, 4'h4);
		pulse(1'b0, 4'h4);
		chk({irq, raw}, 5'h0);
		both <= 1'b0;
		keep = ep;
		repeat (4) mv(1'b0, 1'b0);
		ep = nxt(nxt(keep, 1'b0), 1'b0);
		both <= 1'b1;
		mv(1'b0, 1'b1);
		chk({pe, raw[3]}, 2'h3);
		chk(pos, ep);
		swp <= 1'b1;
		repeat (6) @(posedge sys_clk);
		mv(1'b0, 1'b0);
		chk({dr, pos}, {1'b1, ep});
		swp <= 1'b0;
		irm <= 1'b1;
		repeat (6) @(posedge sys_clk);
		mv(1'b0, 1'b0);
		pulse(1'b1, 4'h0);
		chk({raw[0], pos}, {1'b1, 32'h0});
		mv(1'b1, 1'b0);
		pulse(1'b1, 4'h0);
		chk(pos, lim);
		irm <= 1'b0;
		ep = lim;
		pulse(1'b1, 4'h0);
		chk(pos, ep);
		sd <= 1'b1;
		repeat (6) @(posedge sys_clk);
		pwv <= 32'h2;
		pw <= 1'b1;
		@(posedge sys_clk);
		pw <= 1'b0;
		repeat (4) @(posedge sys_clk);
		ep = 32'h2;
		chk(pos, ep);
		mv(1'b0, 1'b0);
		chk(pos, 32'h3);
		mv(1'b1, 1'b0);
		chk({dr, pos}, {1'b1, 32'h2});
		en <= 1'b0;
		mv(1'b0, 1'b0);
		chk(pos, ep);
		en <= 1'b1;
		ve <= 1'b1;
		repeat (8) mv(1'b0, 1'b0);
		chk(raw[1], 1'b1);
		chk(vc, 32'h2);
		chk(vr, 32'h1);
		en <= 1'b0;
		pulse(1'b0, 4'hf);
		repeat (3) mv(1'b0, 1'b0);
		chk({raw[1], vr}, 33'h1);
		en <= 1'b1;
		pd <= 3'h1;
		repeat (8) mv(1'b0, 1'b0);
		chk({vc, vr}, {32'h1, 32'h1});
		chk(pos, ep);
		stop_test();
	end
endmodule : qpv_top_tb
`default_nettype wire
